// File: sfseq_dev.sv
// Flash device end: decodes security erase/program, reset pair, parameter read and
// single/quad page program; keeps busy/WRITE_ENABLE_LATCH, lock flags, protection and page memory.
// Assumes link pins are asynchronous to clk_i and sampled through synchronisers.
// Contract
// - Security erase needs write enable latch set
// - Security erase valid only at eight bits
// - Security erase runs erase time, clears latch
// - Global lock flag blocks security erase
// - Three 256-byte regions by address fields
// - Security program: latch, opcode, address, data
// - Security program runs program time, clears latch
// - Region lock flag blocks its program
// - Reset clears volatile state and modes
// - Reset only directly after reset enable
// - Reset takes 30us, commands refused meanwhile
// - Host checks busy and suspend first; sfseq_host sends each command without reading status
// - Parameter table opcode is recognised
// - Page program: latch, opcode, address, data
// - Page data wraps within the page
// - Keep last 256 bytes, others untouched
// - Program valid only at byte boundary
// - Page program runs program time, clears latch
// - Protected pages are never programmed
// - Quad program needs quad enable bit
// - Host sends quad program over lanes
// - Bits sampled at rising serial clock
//
// Local design decisions: the address map.
`timescale 1ns/1ps
`include "sfseq_regs.svh"
module sfseq_dev (
	input wire logic clk_i,
	input wire logic rst_i,
	sfseq_link_if.dev link,
	input wire logic [4:0] block_protect_field_i,
	input wire logic quad_lane_enable_i,
	input wire logic secure_lock_flag_i,
	input wire logic [2:0] secure_region_lock_flags_i,
	output logic write_in_progress_o,
	output logic write_enable_latch_o,
	output logic resetting_o,
	output logic param_read_o,
	output logic prog_done_o,
	output logic [23:0] last_addr_o
);
	import sfseq_pkg::*;
	// ==========================================================
	// Link sampling
	logic cs_lvl, cs_rise, cs_fall, sck_rise;
	logic [3:0] dq_s1, dq_s2;
	sfseq_sync u_cs (.clk_i(clk_i), .rst_i(rst_i), .async_i(link.cs_n), .level_o(cs_lvl),
		.rise_o(cs_rise), .fall_o(cs_fall));
	sfseq_sync u_sck (.clk_i(clk_i), .rst_i(rst_i), .async_i(link.sck), .level_o(),
		.rise_o(sck_rise), .fall_o());
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dq_s1 <= 4'h0;
			dq_s2 <= 4'h0;
		end else begin
			dq_s1 <= link.dq;
			dq_s2 <= dq_s1;
		end
	end
	assign link.dev_dq = 4'h0;
	assign link.dev_dq_oe_n = 4'hF;
	// ==========================================================
	// Frame shifter
	typedef enum logic [1:0] {SFSEQ_PH_OP, SFSEQ_PH_ADDR, SFSEQ_PH_DATA} sfseq_phase_t;
	sfseq_phase_t phase;
	logic [7:0] opcode;
	logic [7:0] shift;
	logic [3:0] bit_cnt;
	logic [1:0] addr_bytes;
	logic [23:0] addr;
	logic [8:0] data_cnt;
	logic [7:0] wr_ptr;
	logic quad_data;
	logic [3:0] step;
	logic [7:0] next_byte;
	logic byte_done;
	logic busy;
	logic [31:0] busy_cnt;
	logic reset_armed;
	logic [31:0] rst_cnt;
	logic write_enable_latch;
	logic [7:0] page_buf [0:255];
	logic [255:0] page_mark;
	logic [7:0] sec_mem [0:767];
	logic [7:0] main_mem [0:255];
	logic accept;

	// Bus locked out while resetting; while busy only the reset pair and the parameter read act
	assign accept = (rst_cnt == 32'h0000_0000);
	assign quad_data = (phase == SFSEQ_PH_DATA) && (opcode == `SFSEQ_OP_QPP);
	assign step = quad_data ? 4'h4 : 4'h1;
	assign next_byte = quad_data ? {shift[3:0], dq_s2} : {shift[6:0], dq_s2[0]};
	assign byte_done = sck_rise && !cs_lvl && (bit_cnt + step == 4'h8);

	function automatic logic sec_addr_ok(input logic [23:0] a);
		sec_addr_ok = (a[23:`SFSEQ_SEC_HI_POS] == 8'h00) && (a[11:`SFSEQ_SEC_MID_POS] == 4'h0) &&
			(a[15:`SFSEQ_SEC_SEL_POS] >= 4'h1) && (a[15:`SFSEQ_SEC_SEL_POS] <= 4'h3);
	endfunction : sec_addr_ok

	// Protection from the top of the array by the block protect field; zero protects nothing
	function automatic logic page_protected(input logic [23:0] a, input logic [4:0] bp);
		logic [5:0] lim;
		lim = 6'd0;
		if (bp[2:0] != 3'h0) begin
			lim = (bp[2:0] >= 3'h5) ? 6'h20 : (6'h01 << bp[2:0]);
		end
		page_protected = (bp[2:0] != 3'h0) && ({1'b0, a[22:18]} >= (6'd32 - lim));
	endfunction : page_protected

	always_ff @(posedge clk_i) begin
		if (rst_i || cs_fall) begin
			phase <= SFSEQ_PH_OP;
			bit_cnt <= 4'h0;
			addr_bytes <= 2'h0;
			data_cnt <= 9'h000;
			shift <= 8'h00;
			page_mark <= '0;
		end else if (sck_rise && !cs_lvl && accept) begin
			shift <= next_byte;
			bit_cnt <= byte_done ? 4'h0 : bit_cnt + step;
			if (byte_done) begin
				unique case (phase)
					SFSEQ_PH_OP: begin
						if (next_byte == `SFSEQ_OP_SEC_PROG || next_byte == `SFSEQ_OP_PP ||
							next_byte == `SFSEQ_OP_QPP || next_byte == `SFSEQ_OP_PARAM) begin
							phase <= SFSEQ_PH_ADDR;
						end else begin
							phase <= SFSEQ_PH_DATA;
						end
					end
					SFSEQ_PH_ADDR: begin
						addr_bytes <= addr_bytes + 2'h1;
						if (addr_bytes == 2'h2) begin
							phase <= SFSEQ_PH_DATA;
							wr_ptr <= next_byte;
						end
					end
					SFSEQ_PH_DATA: begin
						page_buf[wr_ptr] <= next_byte;
						page_mark[wr_ptr] <= 1'b1;
						wr_ptr <= wr_ptr + 8'h01;
						if (data_cnt != 9'h100) begin
							data_cnt <= data_cnt + 9'h001;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			opcode <= 8'h00;
			addr <= 24'h000000;
		end else if (byte_done && accept) begin
			if (phase == SFSEQ_PH_OP) begin
				opcode <= next_byte;
			end else if (phase == SFSEQ_PH_ADDR) begin
				addr <= {addr[15:0], next_byte};
			end
		end
	end

	// ==========================================================
	// Command execution at chip select rise
	logic frame_whole;
	logic op_only;
	logic do_erase, do_sprog, do_pp;
	assign frame_whole = (bit_cnt == 4'h0) && accept;
	// Exactly one opcode byte and nothing after it
	assign op_only = frame_whole && (phase == SFSEQ_PH_DATA) && (data_cnt == 9'h000);
	assign do_erase = cs_rise && op_only && !busy && opcode == `SFSEQ_OP_SEC_ERASE && write_enable_latch &&
		!secure_lock_flag_i;
	assign do_sprog = cs_rise && frame_whole && !busy && phase == SFSEQ_PH_DATA &&
		data_cnt != 9'h000 && opcode == `SFSEQ_OP_SEC_PROG && write_enable_latch && sec_addr_ok(addr) &&
		!secure_region_lock_flags_i[addr[13:12] - 2'h1];
	assign do_pp = cs_rise && frame_whole && !busy && phase == SFSEQ_PH_DATA &&
		data_cnt != 9'h000 && write_enable_latch && !page_protected(addr, block_protect_field_i) &&
		(opcode == `SFSEQ_OP_PP ||
		(opcode == `SFSEQ_OP_QPP && quad_lane_enable_i));

	always_ff @(posedge clk_i) begin
		if (rst_i || (rst_cnt == 32'h0000_0001)) begin
			busy <= 1'b0;
			busy_cnt <= 32'h0000_0000;
			write_enable_latch <= 1'b0;
		end else if (rst_cnt != 32'h0000_0000) begin
			busy <= 1'b0;
			busy_cnt <= 32'h0000_0000;
			write_enable_latch <= 1'b0;
		end else if (busy) begin
			busy_cnt <= busy_cnt - 32'h0000_0001;
			if (busy_cnt == 32'h0000_0002) begin
				write_enable_latch <= 1'b0;
			end
			if (busy_cnt == 32'h0000_0001) begin
				busy <= 1'b0;
			end
		end else if (do_erase) begin
			busy <= 1'b1;
			busy_cnt <= `SFSEQ_TSE_CYC;
		end else if (do_sprog || do_pp) begin
			busy <= 1'b1;
			busy_cnt <= `SFSEQ_TPP_CYC;
		end else if (cs_rise && op_only && opcode == `SFSEQ_OP_WREN) begin
			write_enable_latch <= 1'b1;
		end
	end

	// Memory update at the start of the timed cycle
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < `SFSEQ_PAGE_BYTES; i++) begin
			if (do_erase && sec_addr_ok(addr)) begin
				sec_mem[{addr[13:12] - 2'h1, i[7:0]}] <= 8'hFF;
			end else if (do_sprog && page_mark[i]) begin
				sec_mem[{addr[13:12] - 2'h1, i[7:0]}] <= sec_mem[{addr[13:12] - 2'h1, i[7:0]}] &
					page_buf[i];
			end else if (do_pp && page_mark[i]) begin
				main_mem[i] <= main_mem[i] & page_buf[i];
			end
		end
	end

	// ==========================================================
	// Software reset pair
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_armed <= 1'b0;
			rst_cnt <= 32'h0000_0000;
		end else if (rst_cnt != 32'h0000_0000) begin
			rst_cnt <= rst_cnt - 32'h0000_0001;
		end else if (cs_rise && accept) begin
			reset_armed <= op_only && opcode == `SFSEQ_OP_RST_EN;
			if (reset_armed && op_only && opcode == `SFSEQ_OP_RST) begin
				rst_cnt <= `SFSEQ_TRST_CYC;
			end
		end
	end

	// ==========================================================
	// Registered status outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			write_in_progress_o <= 1'b0;
			write_enable_latch_o <= 1'b0;
			resetting_o <= 1'b0;
			param_read_o <= 1'b0;
			prog_done_o <= 1'b0;
			last_addr_o <= 24'h000000;
		end else begin
			write_in_progress_o <= busy;
			write_enable_latch_o <= write_enable_latch;
			resetting_o <= rst_cnt != 32'h0000_0000;
			param_read_o <= byte_done && accept && phase == SFSEQ_PH_OP &&
				next_byte == `SFSEQ_OP_PARAM;
			prog_done_o <= busy && busy_cnt == 32'h0000_0001;
			if (do_erase || do_sprog || do_pp) begin
				last_addr_o <= addr;
			end
		end
	end
endmodule : sfseq_dev

// File: sfseq_regs.svh
// Constants for the flash command sequencer: opcodes, address fields, timings.
// Assumes inclusion from the sequencer package and both link ends.
`ifndef SFSEQ_REGS_SVH
`define SFSEQ_REGS_SVH
// Opcodes
`define SFSEQ_OP_WREN 8'h06
`define SFSEQ_OP_SEC_ERASE 8'h44
`define SFSEQ_OP_SEC_PROG 8'h42
`define SFSEQ_OP_RST_EN 8'h66
`define SFSEQ_OP_RST 8'h99
`define SFSEQ_OP_PARAM 8'h5A
`define SFSEQ_OP_PP 8'h02
`define SFSEQ_OP_QPP 8'h32
// Security region address fields
`define SFSEQ_SEC_HI_POS 16
`define SFSEQ_SEC_SEL_POS 12
`define SFSEQ_SEC_MID_POS 8
`define SFSEQ_PAGE_BYTES 256
// Status field positions in the 16-bit status word
`define SFSEQ_ST_BUSY 0
`define SFSEQ_ST_WEL 1
`define SFSEQ_ST_BP_POS 2
`define SFSEQ_ST_QE 9
`define SFSEQ_ST_SUS 15
`define SFSEQ_STATUS_RST 16'h0000
// Timing in ns at a 10 ns clock
`define SFSEQ_CLK_NS 10
`define SFSEQ_TPP_NS 60000
`define SFSEQ_TSE_NS 200000
`define SFSEQ_TRST_NS 30000
`define SFSEQ_TPP_CYC (`SFSEQ_TPP_NS / `SFSEQ_CLK_NS)
`define SFSEQ_TSE_CYC (`SFSEQ_TSE_NS / `SFSEQ_CLK_NS)
`define SFSEQ_TRST_CYC (`SFSEQ_TRST_NS / `SFSEQ_CLK_NS)
// Host link clock divider half period in clk cycles
`define SFSEQ_SCK_HALF 4'h4
`endif

// File: sfseq_pkg.sv
// Types shared by the flash sequencer ends.
// Assumes the constants header is on the include path.
`include "sfseq_regs.svh"
package sfseq_pkg;
	typedef enum logic [1:0] {SFSEQ_LANE_SINGLE, SFSEQ_LANE_QUAD} sfseq_lane_t;
	typedef enum logic [2:0] {
		SFSEQ_CMD_WREN, SFSEQ_CMD_SEC_ERASE, SFSEQ_CMD_SEC_PROG, SFSEQ_CMD_RST_EN,
		SFSEQ_CMD_RST, SFSEQ_CMD_PARAM, SFSEQ_CMD_PP, SFSEQ_CMD_QPP
	} sfseq_cmd_t;
	function automatic logic [7:0] sfseq_opcode(input sfseq_cmd_t c);
		unique case (c)
			SFSEQ_CMD_WREN: sfseq_opcode = `SFSEQ_OP_WREN;
			SFSEQ_CMD_SEC_ERASE: sfseq_opcode = `SFSEQ_OP_SEC_ERASE;
			SFSEQ_CMD_SEC_PROG: sfseq_opcode = `SFSEQ_OP_SEC_PROG;
			SFSEQ_CMD_RST_EN: sfseq_opcode = `SFSEQ_OP_RST_EN;
			SFSEQ_CMD_RST: sfseq_opcode = `SFSEQ_OP_RST;
			SFSEQ_CMD_PARAM: sfseq_opcode = `SFSEQ_OP_PARAM;
			SFSEQ_CMD_PP: sfseq_opcode = `SFSEQ_OP_PP;
			SFSEQ_CMD_QPP: sfseq_opcode = `SFSEQ_OP_QPP;
		endcase
	endfunction : sfseq_opcode
	// True when three address bytes follow the opcode
	function automatic logic sfseq_has_addr(input sfseq_cmd_t c);
		sfseq_has_addr = (c == SFSEQ_CMD_SEC_PROG) || (c == SFSEQ_CMD_PP) ||
			(c == SFSEQ_CMD_QPP) || (c == SFSEQ_CMD_PARAM);
	endfunction : sfseq_has_addr
endpackage : sfseq_pkg

// File: sfseq_link_if.sv
// Serial flash link: chip select, serial clock and four data lanes.
// Lanes are split into driven value and active-low output enable per party.
`timescale 1ns/1ps
interface sfseq_link_if;
	logic cs_n;
	logic sck;
	logic [3:0] host_dq;
	logic [3:0] host_dq_oe_n;
	logic [3:0] dev_dq;
	logic [3:0] dev_dq_oe_n;
	logic [3:0] dq;
	// Resolved lane level; an undriven lane reads high (pull-up)
	assign dq = (~host_dq_oe_n & host_dq) | (~dev_dq_oe_n & dev_dq) |
		(host_dq_oe_n & dev_dq_oe_n);
	modport host (output cs_n, output sck, output host_dq, output host_dq_oe_n, input dq);
	modport dev (input cs_n, input sck, output dev_dq, output dev_dq_oe_n, input dq);
endinterface : sfseq_link_if

// File: sfseq_sync.sv
// Two-flop synchroniser with rising and falling edge pulses taken after the second flop.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
module sfseq_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic async_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);
	logic meta;
	logic stage;
	logic prev;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= 1'b1;
			stage <= 1'b1;
			prev <= 1'b1;
		end else begin
			meta <= async_i;
			stage <= meta;
			prev <= stage;
		end
	end
	assign level_o = stage;
	assign rise_o = stage & ~prev;
	assign fall_o = ~stage & prev;
endmodule : sfseq_sync

// File: sfseq_host.sv
// Host controller end: frames one command per request over the serial link.
// Assumes the device samples on rising serial clock; the host makes the clock.
`timescale 1ns/1ps
`include "sfseq_regs.svh"
module sfseq_host (
	input wire logic clk_i,
	input wire logic rst_i,
	sfseq_link_if.host link,
	input wire logic start_i,
	input wire sfseq_pkg::sfseq_cmd_t cmd_i,
	input wire logic [23:0] addr_i,
	input wire logic [8:0] len_i,
	input wire logic [7:0] data_i,
	output logic data_req_o,
	output logic busy_o
);
	import sfseq_pkg::*;
	// ==========================================================
	// Frame sequencer
	typedef enum logic [1:0] {SFSEQ_H_IDLE, SFSEQ_H_SHIFT, SFSEQ_H_END} sfseq_hst_t;
	sfseq_hst_t state;
	logic [3:0] div;
	logic [7:0] sh;
	logic [3:0] bits;
	logic [1:0] abytes;
	logic [8:0] left;
	logic [23:0] addr;
	logic in_data;
	logic quad;
	logic cs_n, sck;
	logic [3:0] dq, oe_n;
	sfseq_cmd_t cmd;
	logic [7:0] first_op;
	assign first_op = sfseq_opcode(cmd_i);
	assign link.cs_n = cs_n;
	assign link.sck = sck;
	assign link.host_dq = dq;
	assign link.host_dq_oe_n = oe_n;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= SFSEQ_H_IDLE;
			cs_n <= 1'b1;
			sck <= 1'b0;
			dq <= 4'h0;
			oe_n <= 4'hF;
			div <= 4'h0;
			bits <= 4'h0;
			abytes <= 2'h0;
			left <= 9'h000;
			in_data <= 1'b0;
			quad <= 1'b0;
			data_req_o <= 1'b0;
			busy_o <= 1'b0;
			sh <= 8'h00;
			addr <= 24'h000000;
			cmd <= SFSEQ_CMD_WREN;
		end else begin
			data_req_o <= 1'b0;
			unique case (state)
				SFSEQ_H_IDLE: begin
					if (start_i) begin
						state <= SFSEQ_H_SHIFT;
						cs_n <= 1'b0;
						busy_o <= 1'b1;
						cmd <= cmd_i;
						sh <= first_op;
						addr <= addr_i;
						left <= (len_i == 9'h000) ? 9'h001 : len_i;
						abytes <= 2'h0;
						bits <= 4'h0;
						in_data <= 1'b0;
						quad <= 1'b0;
						div <= 4'h0;
						oe_n <= 4'hE;
						dq <= {3'h0, first_op[7]};
					end
				end
				SFSEQ_H_SHIFT: begin
					div <= div + 4'h1;
					if (div == `SFSEQ_SCK_HALF - 4'h1) begin
						sck <= 1'b1;
					end else if (div == `SFSEQ_SCK_HALF + `SFSEQ_SCK_HALF - 4'h1) begin
						div <= 4'h0;
						sck <= 1'b0;
						if (bits + (quad ? 4'h4 : 4'h1) == 4'h8) begin
							bits <= 4'h0;
							if (!in_data && sfseq_has_addr(cmd) && abytes != 2'h3) begin
								abytes <= abytes + 2'h1;
								sh <= addr[23:16];
								dq <= {3'h0, addr[23]};
								addr <= {addr[15:0], 8'h00};
							end else if (sfseq_has_addr(cmd) && left != 9'h000 &&
								cmd != SFSEQ_CMD_PARAM) begin
								in_data <= 1'b1;
								quad <= cmd == SFSEQ_CMD_QPP;
								oe_n <= (cmd == SFSEQ_CMD_QPP) ? 4'h0 : 4'hE;
								left <= left - 9'h001;
								sh <= data_i;
								data_req_o <= 1'b1;
								dq <= (cmd == SFSEQ_CMD_QPP) ? data_i[7:4] : {3'h0, data_i[7]};
							end else begin
								state <= SFSEQ_H_END;
							end
						end else begin
							bits <= bits + (quad ? 4'h4 : 4'h1);
							sh <= quad ? {sh[3:0], 4'h0} : {sh[6:0], 1'b0};
							dq <= quad ? sh[3:0] : {3'h0, sh[6]};
						end
					end
				end
				SFSEQ_H_END: begin
					cs_n <= 1'b1;
					oe_n <= 4'hF;
					busy_o <= 1'b0;
					state <= SFSEQ_H_IDLE;
				end
			endcase
		end
	end
endmodule : sfseq_host

// File: sfseq_link_assertions.sv
// Checker for the serial link between the host and device ends of the sequencer.
// Assumes the host end drives chip select, clock and lanes from clk_i.
`timescale 1ns/1ps
`include "sfseq_regs.svh"
module sfseq_link_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic [3:0] host_dq,
	input wire logic [3:0] host_dq_oe_n,
	input wire logic [3:0] dev_dq_oe_n,
	input wire logic [3:0] dq
);
	logic sck_q;
	logic cs_q;
	logic rise;
	logic [11:0] bits;
	logic [7:0] op;
	assign rise = !cs_n && sck && !sck_q;
	// ====================
	// Frame bookkeeping
	always_ff @(posedge clk_i) begin
		sck_q <= sck;
		cs_q <= cs_n;
	end
	always_ff @(posedge clk_i) begin
		if (rst_i || (cs_q && !cs_n)) begin
			bits <= 12'h000;
		end else if (rise) begin
			bits <= bits + 12'h001;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			op <= 8'h00;
		end else if (rise && bits < 12'h008) begin
			op <= {op[6:0], dq[0]};
		end
	end
	// ====================
	// Link properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_dev_quiet: assert property (dev_dq_oe_n == 4'hF)
		else $error("device end drove a lane");
	a_sck_idle: assert property (cs_n |-> !sck)
		else $error("serial clock high outside a frame");
	a_cs_setup: assert property ($fell(cs_n) |-> !sck [*2])
		else $error("serial clock rose too soon after select");
	a_bit_stable: assert property ($rose(sck) |-> $stable(host_dq) [*4])
		else $error("lane changed around the sampling edge");
	a_sck_high: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
		else $error("serial clock high phase not four cycles");
	a_si_driven: assert property (!cs_n |-> !host_dq_oe_n[0])
		else $error("serial input not driven in a frame");
	a_whole_bytes: assert property ($rose(cs_n) |-> bits != 12'h000 &&
		(op == `SFSEQ_OP_QPP ? !bits[0] : bits[2:0] == 3'h0))
		else $error("frame ended inside a byte");
	a_reset_frame: assert property ($rose(cs_n) &&
		(op == `SFSEQ_OP_RST_EN || op == `SFSEQ_OP_RST) |-> bits == 12'h008)
		else $error("reset frame not eight clocks");
	a_quad_lanes: assert property (rise && op == `SFSEQ_OP_QPP &&
		bits >= 12'h020 |-> host_dq_oe_n == 4'h0)
		else $error("quad data not on all lanes");
endmodule : sfseq_link_assertions

// File: sfseq_tb.sv
// Bench: host and device ends joined by one link, a second device fed bit by bit.
// Assumes the timing counts of the shared constants header.
`timescale 1ns/1ps
`include "sfseq_regs.svh"
module sfseq_tb;
	import sfseq_pkg::*;
	typedef struct {
		sfseq_cmd_t cmd;
		logic wren;
		logic [23:0] addr;
		logic [4:0] bp;
		logic qe;
		logic [3:0] lock;
		logic write_in_progress;
	} sfseq_row_t;
	logic clk_i, rst_i, start_i, qe, busy, write_in_progress, write_enable_latch, rsting, pread, pdone, wip2, wel2, dreq;
	sfseq_cmd_t cmd_i;
	logic [23:0] addr_i, last_addr;
	logic [8:0] len_i;
	logic [7:0] data_i;
	logic [4:0] bp;
	logic [3:0] lock;
	int err_count, n_checks, n, mark, pd_cnt, pr_cnt, dr_cnt;
	sfseq_row_t rows [11] = '{
		'{SFSEQ_CMD_SEC_ERASE, 1'b0, 24'h00_0000, 5'h00, 1'b0, 4'h0, 1'b0},
		'{SFSEQ_CMD_PP, 1'b0, 24'h00_0000, 5'h00, 1'b0, 4'h0, 1'b0},
		'{SFSEQ_CMD_SEC_ERASE, 1'b1, 24'h00_0000, 5'h00, 1'b0, 4'h0, 1'b1},
		'{SFSEQ_CMD_SEC_ERASE, 1'b1, 24'h00_0000, 5'h00, 1'b0, 4'h8, 1'b0},
		'{SFSEQ_CMD_SEC_PROG, 1'b1, 24'h00_1010, 5'h00, 1'b0, 4'h0, 1'b1},
		'{SFSEQ_CMD_SEC_PROG, 1'b1, 24'h00_3000, 5'h00, 1'b0, 4'h4, 1'b0},
		'{SFSEQ_CMD_SEC_PROG, 1'b1, 24'h00_2000, 5'h00, 1'b0, 4'h5, 1'b1},
		'{SFSEQ_CMD_PP, 1'b1, 24'h7F_FF00, 5'h01, 1'b0, 4'h0, 1'b0},
		'{SFSEQ_CMD_PP, 1'b1, 24'h00_0000, 5'h01, 1'b0, 4'h0, 1'b1},
		'{SFSEQ_CMD_QPP, 1'b1, 24'h00_0100, 5'h00, 1'b0, 4'h0, 1'b0},
		'{SFSEQ_CMD_QPP, 1'b1, 24'h00_0100, 5'h00, 1'b1, 4'h0, 1'b1}
	};
	sfseq_link_if link ();
	sfseq_link_if link2 ();
	sfseq_host u_sfseq_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .start_i(start_i),
		.cmd_i(cmd_i), .addr_i(addr_i), .len_i(len_i), .data_i(data_i), .data_req_o(dreq),
		.busy_o(busy));
	sfseq_dev u_sfseq_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link),
		.block_protect_field_i(bp), .quad_lane_enable_i(qe), .secure_lock_flag_i(lock[3]),
		.secure_region_lock_flags_i(lock[2:0]), .write_in_progress_o(write_in_progress),
		.write_enable_latch_o(write_enable_latch), .resetting_o(rsting), .param_read_o(pread),
		.prog_done_o(pdone), .last_addr_o(last_addr));
	sfseq_dev u_sfseq_dev_b (.clk_i(clk_i), .rst_i(rst_i), .link(link2),
		.block_protect_field_i(bp), .quad_lane_enable_i(qe), .secure_lock_flag_i(lock[3]),
		.secure_region_lock_flags_i(lock[2:0]), .write_in_progress_o(wip2),
		.write_enable_latch_o(wel2), .resetting_o(), .param_read_o(), .prog_done_o(),
		.last_addr_o());
	sfseq_link_assertions u_sfseq_link_assertions (.clk_i(clk_i), .rst_i(rst_i),
		.cs_n(link.cs_n), .sck(link.sck), .host_dq(link.host_dq),
		.host_dq_oe_n(link.host_dq_oe_n), .dev_dq_oe_n(link.dev_dq_oe_n), .dq(link.dq));
	// ====================
	// Helpers
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (pdone === 1'b1) pd_cnt++;
		if (pread === 1'b1) pr_cnt++;
		if (dreq === 1'b1) dr_cnt++;
	end
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic check_span(input string what, input int lo, input int hi, input int got);
		n_checks++;
		if (got < lo || got > hi) begin
			err_count++;
			$display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : check_span
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish
	function automatic logic flag(input int s);
		case (s)
			0: return write_in_progress;
			1: return rsting;
			default: return busy;
		endcase
	endfunction : flag
	// Counts cycles until the chosen flag drops; a hang ends the run
	task automatic wait_clear(input int s, input int lim, output int cnt);
		cnt = 0;
		while (flag(s) !== 1'b0) begin
			@(posedge clk_i);
			#1;
			cnt++;
			if (cnt > lim) begin
				err_count++;
				$display("Error wait on flag %0d expected clear seen set", s);
				tally_and_finish();
			end
		end
	endtask : wait_clear
	task automatic run_cmd(input sfseq_cmd_t c, input logic [23:0] a, input logic [8:0] l);
		int k;
		@(posedge clk_i);
		start_i <= 1'b1;
		cmd_i <= c;
		addr_i <= a;
		len_i <= l;
		@(posedge clk_i);
		start_i <= 1'b0;
		@(posedge clk_i);
		#1;
		wait_clear(2, 4000, k);
		repeat (8) @(posedge clk_i);
		#1;
	endtask : run_cmd
	task automatic op1(input sfseq_cmd_t c);
		run_cmd(c, 24'h00_0000, 9'h001);
	endtask : op1
	// Reset pair, with a write enable sent while the reset is still running
	task automatic soft_reset;
		op1(SFSEQ_CMD_RST_EN);
		op1(SFSEQ_CMD_RST);
		check("resetting", 1'b1, rsting);
		op1(SFSEQ_CMD_WREN);
		wait_clear(1, 4000, n);
		check_span("reset cycles", `SFSEQ_TRST_CYC - 200, `SFSEQ_TRST_CYC, n);
		check("wip after reset", 1'b0, write_in_progress);
		check("wel after reset", 1'b0, write_enable_latch);
	endtask : soft_reset
	task automatic frame2(input logic [39:0] v, input int nb);
		@(posedge clk_i);
		link2.cs_n <= 1'b0;
		for (int i = 39; i > 39 - nb; i--) begin
			repeat (4) @(posedge clk_i);
			link2.host_dq <= {3'b111, v[i]};
			repeat (4) @(posedge clk_i);
			link2.sck <= 1'b1;
			repeat (4) @(posedge clk_i);
			link2.sck <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		link2.cs_n <= 1'b1;
		repeat (12) @(posedge clk_i);
		#1;
	endtask : frame2
	// ====================
	// Main sequence
	initial begin
		rst_i = 1'b1;
		start_i = 1'b0;
		cmd_i = SFSEQ_CMD_WREN;
		addr_i = 24'h00_0000;
		len_i = 9'h001;
		data_i = 8'hA5;
		bp = 5'h00;
		qe = 1'b0;
		lock = 4'h0;
		link2.cs_n = 1'b1;
		link2.sck = 1'b0;
		link2.host_dq = 4'hF;
		link2.host_dq_oe_n = 4'hE;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		#1;
		check("wip at reset", 1'b0, write_in_progress);
		check("wel at reset", 1'b0, write_enable_latch);
		foreach (rows[i]) begin
			@(posedge clk_i);
			bp <= rows[i].bp;
			qe <= rows[i].qe;
			lock <= rows[i].lock;
			if (rows[i].wren) begin
				op1(SFSEQ_CMD_WREN);
				check("wel set", 1'b1, write_enable_latch);
			end
			run_cmd(rows[i].cmd, rows[i].addr, 9'h004);
			check("wip", rows[i].write_in_progress, write_in_progress);
			if (rows[i].write_in_progress && rows[i].cmd != SFSEQ_CMD_SEC_ERASE) begin
				check("address", rows[i].addr, last_addr);
			end
			if (rows[i].wren || rows[i].write_in_progress) soft_reset();
			$display("row %0d done", i);
		end
		@(posedge clk_i);
		bp <= 5'h00;
		lock <= 4'h0;
		op1(SFSEQ_CMD_WREN);
		mark = pd_cnt;
		n = dr_cnt;
		run_cmd(SFSEQ_CMD_PP, 24'h00_01F0, 9'h014);
		check("data requests", 24'h00_0014, 24'(dr_cnt - n));
		check("wip program", 1'b1, write_in_progress);
		op1(SFSEQ_CMD_WREN);
		wait_clear(0, 7000, n);
		check_span("program cycles", `SFSEQ_TPP_CYC - 200, `SFSEQ_TPP_CYC, n);
		check("wel after program", 1'b0, write_enable_latch);
		check("done pulses", 24'h00_0001, 24'(pd_cnt - mark));
		check("program address", 24'h00_01F0, last_addr);
		$display("page program done");
		op1(SFSEQ_CMD_WREN);
		check("wip before reset", 1'b0, write_in_progress);
		op1(SFSEQ_CMD_RST_EN);
		mark = pr_cnt;
		op1(SFSEQ_CMD_PARAM);
		check("param pulses", 24'h00_0001, 24'(pr_cnt - mark));
		op1(SFSEQ_CMD_RST);
		check("resetting disarmed", 1'b0, rsting);
		check("wel kept", 1'b1, write_enable_latch);
		soft_reset();
		$display("reset disarm done");
		frame2({`SFSEQ_OP_WREN, 32'h0000_0000}, 8);
		check("wel link2", 1'b1, wel2);
		frame2({`SFSEQ_OP_PP, 24'h00_0100, 8'hA5}, 36);
		frame2({`SFSEQ_OP_SEC_ERASE, 32'h0000_0000}, 9);
		check("wip partial frames", 1'b0, wip2);
		frame2({`SFSEQ_OP_WREN, 32'h0000_0000}, 8);
		frame2({`SFSEQ_OP_SEC_ERASE, 32'h0000_0000}, 8);
		check("wip whole erase", 1'b1, wip2);
		$display("framing faults done");
		tally_and_finish();
	end
endmodule : sfseq_tb
